// ### bench/awt_front_end.sv
// sampling front end model that feeds the trigger one sample per push
`timescale 1ns/1ps
module awt_front_end
    import awt_pkg::*;
(
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    output awt_smp_s  smp_out
);
    int unsigned next_idx;

    // index of the next sample handed over, restarts with the detector
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            next_idx = 0;
        end
    end

    // each call raises valid and leaves it high until idle or the next call; back-to-back calls give a sample a cycle
    task automatic push(input logic signed [SMP_W-1:0] v);
        @(posedge core_clk_in);
        smp_out <= '{valid: 1'b1, data: v};
        next_idx = next_idx + 1;
    endtask

    // released bus: data flips every cycle so stale values never look real
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk_in);
            smp_out <= '{valid: 1'b0, data: ~smp_out.data};
        end
    endtask

    initial smp_out = '0;
endmodule

// ### bench/awt_trigger_tb_top.sv
// self-checking bench for the window, voltage-drop and period trigger
`timescale 1ns/1ps
module awt_trigger_tb_top;
    import awt_pkg::*;
    localparam logic signed [SMP_W-1:0] HI  = 16'sh0100;
    localparam logic signed [SMP_W-1:0] LO  = -16'sh0100;
    localparam logic signed [SMP_W-1:0] BIG = 16'sh2000;
    localparam logic signed [SMP_W-1:0] SML = 16'sh0800;
    logic             core_clk_in;
    logic             reset_in;
    logic             ce_in;
    logic             other_met_in;
    logic             other_evt_in;
    awt_cfg_s         cfg_in;
    awt_cfg_s         cf;
    awt_smp_s         smp_in;
    logic             trig_out;
    logic [IDX_W-1:0] trig_pos_out;
    logic [SMP_W-1:0] drop_rms_out;
    logic [IDX_W-1:0] last_pos;
    logic [31:0]      c;
    logic [31:0]      c0;
    logic [31:0]      e;
    int               bad_count;
    int               n_tests;
    int               trig_cnt;
    int               base;
    int               d;

    // small counts keep the filter and mains windows short in simulation
    awt_trigger #(
        .REC_FILT_CYCLES (20),
        .HALF_50_CYCLES  (20),
        .HALF_60_CYCLES  (16)
    ) i_awt_trigger (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .ce_in        (ce_in),
        .cfg_in       (cfg_in),
        .smp_in       (smp_in),
        .other_met_in (other_met_in),
        .other_evt_in (other_evt_in),
        .trig_out     (trig_out),
        .trig_pos_out (trig_pos_out),
        .drop_rms_out (drop_rms_out)
    );

    awt_front_end i_awt_front_end (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .smp_out     (smp_in)
    );

    initial core_clk_in = 1'b0;
    always #25 core_clk_in = ~core_clk_in;

    // trigger pulses are one cycle wide, so every edge is looked at
    always @(posedge core_clk_in) begin
        if (trig_out === 1'b1) begin
            trig_cnt = trig_cnt + 1;
            last_pos = trig_pos_out;
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // legal settings only: band not inverted, period limits in range
    function automatic awt_cfg_s base_cfg(input awt_mode_e m);
        awt_cfg_s f;
        f = '0;
        f.mode             = m;
        f.func             = AWT_FN_MEMORY;
        f.win_upper        = 16'sh0040;
        f.win_lower        = -16'sh0040;
        f.tenth_div_cycles = 16'h0002;
        f.drop_level       = 16'h1000;
        f.drop_range_ok    = 1'b1;
        f.per_rising       = 1'b1;
        f.per_lower        = 16'h000c;
        f.per_upper        = 16'h001e;
        return f;
    endfunction

    // reset between scenarios so sample indices start again from zero;
    // the strobe drops first, or a stale sample would count as index 0
    task automatic restart(input awt_cfg_s f);
        i_awt_front_end.idle(1);
        reset_in <= 1'b1;
        cfg_in   <= f;
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(negedge core_clk_in);
        base = trig_cnt;
    endtask

    task automatic run(input logic signed [SMP_W-1:0] v, input int n);
        repeat (n) i_awt_front_end.push(v);
    endtask

    task automatic alt(input logic signed [SMP_W-1:0] a,
                       input logic signed [SMP_W-1:0] b, input int n);
        repeat (n) begin
            i_awt_front_end.push(a);
            i_awt_front_end.push(b);
        end
    endtask

    // gap samples, the last one crossing the reference
    task automatic cyc(input int gap, input logic signed [SMP_W-1:0] a);
        run(a, gap - 1);
        c = i_awt_front_end.next_idx;
        i_awt_front_end.push(-a);
    endtask

    // let pending pulses land, then compare the count since restart
    task automatic fired(input int n);
        i_awt_front_end.idle(4);
        @(negedge core_clk_in);
        chk(32'(trig_cnt - base), 32'(n));
    endtask

    initial begin
        repeat (20000) @(posedge core_clk_in);
        bad_count = bad_count + 1;
        wrap_up();
    end

    initial begin
        reset_in     = 1'b1;
        ce_in        = 1'b1;
        other_met_in = 1'b0;
        other_evt_in = 1'b0;
        cfg_in       = base_cfg(AWT_MODE_OFF);
        repeat (6) @(posedge core_clk_in);
        reset_in <= 1'b0;
        // band edges are inclusive, so the limit values themselves count
        restart(base_cfg(AWT_MODE_WIN_IN));
        run(16'sh0041, 1);
        run(16'sh0040, 1);
        run(-16'sh0041, 1);
        run(-16'sh0040, 1);
        fired(2);
        chk(last_pos, 32'h3);
        restart(base_cfg(AWT_MODE_WIN_OUT));
        run(16'sh0000, 1);
        run(16'sh0041, 1);
        run(16'sh0000, 1);
        run(-16'sh0041, 1);
        fired(2);
        chk(last_pos, 32'h3);
        // filter of 2 tenths at 2 clocks each is 4 clocks wide
        cf = base_cfg(AWT_MODE_WIN_IN);
        cf.filt_tenths = 7'h02;
        restart(cf);
        run(HI, 1);
        run(16'sh0000, 2);
        run(HI, 3);
        fired(0);
        run(16'sh0000, 10);
        fired(1);
        // chart recording ignores the tenths and uses the fixed width
        cf.func = AWT_FN_CHART_REC;
        cf.rec_filt_on = 1'b1;
        restart(cf);
        run(HI, 1);
        run(16'sh0000, 10);
        run(HI, 3);
        fired(0);
        run(16'sh0000, 30);
        fired(1);
        cf = base_cfg(AWT_MODE_WIN_IN);
        cf.link_and = 1'b1;
        restart(cf);
        run(HI, 1);
        run(16'sh0000, 1);
        fired(0);
        @(posedge core_clk_in);
        other_met_in <= 1'b1;
        run(HI, 1);
        run(16'sh0000, 1);
        fired(1);
        restart(base_cfg(AWT_MODE_WIN_IN));
        @(posedge core_clk_in);
        other_evt_in <= 1'b1;
        @(posedge core_clk_in);
        other_evt_in <= 1'b0;
        fired(1);
        // rms shown beside the level: peak times 1/sqrt2 in Q15
        for (int i = 0; i < 16; i += 5) begin
            cf = base_cfg(AWT_MODE_VDROP);
            cf.drop_level = 16'hffff >> i;
            e = (32'(cf.drop_level) * 32'(INV_SQRT2_Q15)) >> Q15_SHIFT;
            restart(cf);
            // the output first follows the level at the edge after reset
            @(negedge core_clk_in);
            chk(32'(drop_rms_out), e);
        end
        // mains windows: big peaks of either sign hold the trigger off
        for (int m = 0; m < 2; m++) begin
            cf = base_cfg(AWT_MODE_VDROP);
            cf.mains_60 = m[0];
            restart(cf);
            alt(BIG, -BIG, 20);
            @(negedge core_clk_in);
            base = trig_cnt;
            alt(BIG, -BIG, 40);
            alt(-BIG, 16'sh0000, 40);
            @(negedge core_clk_in);
            chk(32'(trig_cnt - base), 32'h0);
            // settle the window phase, then count whole windows only
            alt(SML, -SML, 20);
            @(negedge core_clk_in);
            base = trig_cnt;
            alt(SML, -SML, 160);
            @(negedge core_clk_in);
            d = trig_cnt - base - (m == 1 ? 20 : 16);
            chk(32'(d), 32'h0);
            chk(32'(d >= -16), 32'h1);
        end
        cf.drop_range_ok = 1'b0;
        restart(cf);
        alt(SML, -SML, 40);
        @(negedge core_clk_in);
        chk(32'(trig_cnt - base), 32'h0);
        // crossings of the other direction must not count as boundaries
        for (int r = 0; r < 2; r++) begin
            cf = base_cfg(AWT_MODE_PERIOD);
            cf.per_rising = r[0];
            restart(cf);
            cyc(20, r ? LO : HI);
            cyc(20, r ? LO : HI);
            fired(0);
            cyc(5, r ? LO : HI);
            fired(1);
            chk(last_pos, c);
            c0 = c;
            cyc(40, r ? LO : HI);
            fired(2);
            chk(32'(last_pos == c0 + 30 || last_pos == c0 + 29), 32'h1);
            cyc(20, r ? LO : HI);
            fired(2);
        end
        wrap_up();
    end
endmodule

// ### rtl/awt_pkg.sv
// shared types and constants for the analog window/drop/period trigger
package awt_pkg;

    // sample and setting widths
    localparam int SMP_W    = 16;
    localparam int PER_W    = 16;
    localparam int FILT_W   = 24;
    localparam int TENTHS_W = 7;
    localparam int IDX_W    = 32;

    // filter width in tenths of a division: 1 = 0.1 div, 100 = 10.0 div
    localparam logic [TENTHS_W-1:0] FILT_TENTHS_OFF = 7'h00;
    localparam logic [TENTHS_W-1:0] FILT_TENTHS_MAX = 7'h64;

    // timing
    localparam longint CLK_HZ      = 20_000_000;
    localparam longint REC_FILT_MS = 10;
    localparam longint MAINS_LO_HZ = 50;
    localparam longint MAINS_HI_HZ = 60;
    localparam int REC_FILT_CYC  = int'((REC_FILT_MS * CLK_HZ) / 1000);
    localparam int HALF_LO_CYC   = int'(CLK_HZ / (2 * MAINS_LO_HZ));
    localparam int HALF_HI_CYC   = int'(CLK_HZ / (2 * MAINS_HI_HZ));

    // 1/sqrt(2) as a Q15 fraction
    localparam logic [15:0] INV_SQRT2_Q15 = 16'h5a82;
    localparam int          Q15_SHIFT     = 15;

    // detection kinds
    typedef enum logic [4:0] {
        AWT_MODE_OFF     = 5'h01,
        AWT_MODE_WIN_IN  = 5'h02,
        AWT_MODE_WIN_OUT = 5'h04,
        AWT_MODE_VDROP   = 5'h08,
        AWT_MODE_PERIOD  = 5'h10
    } awt_mode_e;

    // acquisition functions
    typedef enum logic [3:0] {
        AWT_FN_MEMORY    = 4'h1,
        AWT_FN_CHART_REC = 4'h2,  // chart_recording_function
        AWT_FN_COMBINED  = 4'h4,  // combined_capture_function
        AWT_FN_SPECTRUM  = 4'h8   // spectrum_function
    } awt_func_e;

    // static configuration, held steady while armed
    typedef struct packed {
        awt_mode_e                  mode;
        awt_func_e                  func;
        logic signed [SMP_W-1:0]    win_upper;
        logic signed [SMP_W-1:0]    win_lower;
        logic [TENTHS_W-1:0]        filt_tenths;
        logic                       rec_filt_on;
        logic [PER_W-1:0]           tenth_div_cycles;
        logic [SMP_W-1:0]           drop_level;
        logic                       mains_60;
        logic                       drop_range_ok;
        logic signed [SMP_W-1:0]    per_ref;
        logic                       per_rising;
        logic [PER_W-1:0]           per_lower;
        logic [PER_W-1:0]           per_upper;
        logic                       link_and;
    } awt_cfg_s;

    // one sample from the front end
    typedef struct packed {
        logic                    valid;
        logic signed [SMP_W-1:0] data;
    } awt_smp_s;

endpackage

// ### rtl/awt_trigger.sv
// window, voltage-drop and period trigger detector for one analog channel
// How it works
// - window-in fires when a sample moves from outside the band to inside
// - window-out fires when a sample moves from inside the band to outside
// - memory, combined, spectrum: filter off or 0.1 to 10.0 divisions
// - chart recording: filter only on or off, fixed at 10 ms
// - with filter on, condition must hold the whole width before firing
// - voltage drop fires when the mains peak falls below the level
// - one magnitude level serves positive and negative peaks alike
// - mains frequency is selectable as 50 Hz or 60 Hz
// - voltage drop only works when the time or frequency range allows it
// - rms equivalent of the drop level is peak over root two
// - period mode fires when crossing interval leaves the set range
// - period boundaries are rising or falling reference crossings
// - early crossing places trigger position at that crossing
// - missing crossing places trigger position where upper limit expires
// - period mode has no filter; every crossing in the chosen direction counts
// - OR: any source fires; AND: all sources satisfied together
`timescale 1ns/1ps
module awt_trigger
    import awt_pkg::*;
#(
    parameter int REC_FILT_CYCLES = REC_FILT_CYC,
    parameter int HALF_50_CYCLES  = HALF_LO_CYC,
    parameter int HALF_60_CYCLES  = HALF_HI_CYC
) (
    input  wire logic              core_clk_in,
    input  wire logic              reset_in,
    input  wire logic              ce_in,
    input  wire awt_cfg_s          cfg_in,
    input  wire awt_smp_s          smp_in,
    input  wire logic              other_met_in,
    input  wire logic              other_evt_in,
    output logic                   trig_out,
    output logic [IDX_W-1:0]       trig_pos_out,
    output logic [SMP_W-1:0]       drop_rms_out
);

    // ---------------- sample bookkeeping ----------------
    logic [IDX_W-1:0]        idx_q;
    logic                    seen_q;
    logic signed [SMP_W-1:0] prev_q;
    logic                    take;
    logic [IDX_W-1:0]        idx_now;

    assign take    = ce_in & smp_in.valid;
    // events between samples point at the last sample taken
    assign idx_now = smp_in.valid ? idx_q : idx_q - 32'h1;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            idx_q  <= '0;
            seen_q <= 1'b0;
            prev_q <= '0;
        end else if (take) begin
            idx_q  <= idx_q + 32'h1;
            seen_q <= 1'b1;
            prev_q <= smp_in.data;
        end
    end

    // ---------------- window detector ----------------
    logic inside_now;
    logic want_in;
    logic win_mode;
    logic cond_now;
    logic cond_q;
    logic win_edge;
    // an inverted band is never inside, which is harmless but useless
    assign inside_now = (smp_in.data >= cfg_in.win_lower) &&
                        (smp_in.data <= cfg_in.win_upper);
    assign want_in    = (cfg_in.mode == AWT_MODE_WIN_IN);
    assign win_mode   = want_in | (cfg_in.mode == AWT_MODE_WIN_OUT);
    assign cond_now   = want_in ? inside_now : ~inside_now;
    assign win_edge   = take & seen_q & win_mode & cond_now & ~cond_q;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cond_q <= 1'b0;
        end else if (take) begin
            cond_q <= cond_now;
        end
    end

    // filter width in clock cycles, zero means off
    logic [TENTHS_W-1:0] tenths_lim;
    logic [FILT_W-1:0]   filt_div_w;
    logic [FILT_W-1:0]   filt_w;
    logic                is_chart;
    assign is_chart   = (cfg_in.func == AWT_FN_CHART_REC);
    assign tenths_lim = (cfg_in.filt_tenths > FILT_TENTHS_MAX) ?
                        FILT_TENTHS_MAX : cfg_in.filt_tenths;
    assign filt_div_w = FILT_W'(tenths_lim * cfg_in.tenth_div_cycles);
    assign filt_w     = is_chart ?
                        (cfg_in.rec_filt_on ? FILT_W'(REC_FILT_CYCLES)
                                            : '0)
                        : filt_div_w;

    // qualify the condition for the full width before firing
    logic              filt_busy_q;
    logic [FILT_W-1:0] filt_cnt_q;
    logic              cond_hold;
    logic              filt_done;
    logic              win_evt;
    logic              filt_on;
    assign filt_on   = (filt_w != '0);
    assign cond_hold = smp_in.valid ? cond_now : cond_q;
    assign filt_done = filt_busy_q & cond_hold &
                       (filt_cnt_q + 24'h1 >= filt_w);
    assign win_evt   = filt_on ? (ce_in & filt_done) : win_edge;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            filt_busy_q <= 1'b0;
            filt_cnt_q  <= '0;
        end else if (ce_in) begin
            if (win_edge && filt_on) begin
                filt_busy_q <= 1'b1;
                filt_cnt_q  <= '0;
            end else if (filt_busy_q && (!cond_hold || filt_done)) begin
                filt_busy_q <= 1'b0;
            end else if (filt_busy_q) begin
                filt_cnt_q  <= filt_cnt_q + 24'h1;
            end
        end
    end

    // ---------------- voltage-drop detector ----------------
    logic [SMP_W:0]    mag;
    logic [SMP_W:0]    peak_q;
    logic [FILT_W-1:0] half_cnt_q;
    logic [FILT_W-1:0] half_len;
    logic              half_end;
    logic              drop_mode;
    logic              drop_evt;
    // magnitude folds both polarities onto one level
    assign mag       = smp_in.data[SMP_W-1] ?
                       (SMP_W+1)'(-smp_in.data) :
                       {1'b0, smp_in.data};
    assign half_len  = cfg_in.mains_60 ? FILT_W'(HALF_60_CYCLES)
                                       : FILT_W'(HALF_50_CYCLES);
    assign half_end  = (half_cnt_q + 24'h1 >= half_len);
    assign drop_mode = (cfg_in.mode == AWT_MODE_VDROP) &
                       cfg_in.drop_range_ok;
    assign drop_evt  = ce_in & drop_mode & half_end & seen_q &
                       (peak_q < {1'b0, cfg_in.drop_level});

    // a half mains period always holds one crest of either sign
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            half_cnt_q <= '0;
            peak_q     <= '0;
        end else if (ce_in) begin
            if (half_end) begin
                half_cnt_q <= '0;
                peak_q     <= take ? mag : '0;
            end else begin
                half_cnt_q <= half_cnt_q + 24'h1;
                if (take && mag > peak_q) begin
                    peak_q <= mag;
                end
            end
        end
    end

    // rms equivalent for display
    logic [31:0] rms_prod;
    assign rms_prod = cfg_in.drop_level * INV_SQRT2_Q15;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            drop_rms_out <= '0;
        end else if (ce_in) begin
            drop_rms_out <= rms_prod[Q15_SHIFT +: SMP_W];
        end
    end

    // ---------------- period detector ----------------
    logic             per_mode;
    logic             xing;
    logic             per_armed_q;
    logic             per_exp_q;
    logic [PER_W-1:0] per_cnt_q;
    logic [PER_W-1:0] interval;
    logic             per_early;
    logic             per_late;
    logic             per_evt;

    assign per_mode  = (cfg_in.mode == AWT_MODE_PERIOD);
    // no filtering: any crossing in the chosen direction counts
    assign xing      = take & seen_q & per_mode & (cfg_in.per_rising ?
                       (prev_q < cfg_in.per_ref &&
                        smp_in.data >= cfg_in.per_ref) :
                       (prev_q > cfg_in.per_ref &&
                        smp_in.data <= cfg_in.per_ref));
    assign interval  = (per_cnt_q == '1) ? per_cnt_q
                                         : per_cnt_q + 16'h1;
    assign per_early = xing & per_armed_q &
                       (interval < cfg_in.per_lower);
    assign per_late  = take & per_mode & ~xing & per_armed_q &
                       ~per_exp_q &
                       (interval == cfg_in.per_upper);
    assign per_evt   = per_early | per_late;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            per_cnt_q   <= '0;
            per_armed_q <= 1'b0;
            per_exp_q   <= 1'b0;
        end else if (take) begin
            if (xing) begin
                per_cnt_q   <= '0;
                per_armed_q <= 1'b1;
                per_exp_q   <= 1'b0;
            end else begin
                per_cnt_q <= interval;
                if (per_late) begin
                    per_exp_q <= 1'b1;
                end
            end
        end
    end

    // ---------------- source selection and linking ----------------
    logic analog_evt;
    logic fire;

    always_comb begin
        analog_evt = 1'b0;
        unique case (cfg_in.mode)
            AWT_MODE_OFF:     analog_evt = 1'b0;
            AWT_MODE_WIN_IN:  analog_evt = win_evt;
            AWT_MODE_WIN_OUT: analog_evt = win_evt;
            AWT_MODE_VDROP:   analog_evt = drop_evt;
            AWT_MODE_PERIOD:  analog_evt = per_evt;
            default:          analog_evt = 1'b0;
        endcase
    end

    assign fire = cfg_in.link_and ? (analog_evt & other_met_in)
                                  : (analog_evt |
                                     (ce_in & other_evt_in));

    // registered event and its sample position
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            trig_out     <= 1'b0;
            trig_pos_out <= '0;
        end else if (ce_in) begin
            trig_out <= fire;
            if (fire) begin
                trig_pos_out <= idx_now;
            end
        end
    end

    // ---------------- checks ----------------
    property p_win_unfiltered;
        @(posedge core_clk_in) disable iff (reset_in)
        (ce_in && !filt_on && win_edge && !cfg_in.link_and) |=> trig_out;
    endproperty
    a_win_unfiltered: assert property (p_win_unfiltered)
        else $error("window edge without filter did not fire");
    property p_win_needs_change;
        @(posedge core_clk_in) disable iff (reset_in)
        (take && win_mode && cond_q && !filt_on && !other_evt_in) |=>
            !trig_out;
    endproperty
    a_win_needs_change: assert property (p_win_needs_change)
        else $error("window fired without a band transition");
    property p_filter_hold;
        @(posedge core_clk_in) disable iff (reset_in)
        (ce_in && filt_busy_q && !cond_hold) |=> !filt_busy_q;
    endproperty
    a_filter_hold: assert property (p_filter_hold)
        else $error("filter kept running after condition was lost");
    property p_chart_width;
        @(posedge core_clk_in) disable iff (reset_in)
        (is_chart && cfg_in.rec_filt_on) |->
            (filt_w == FILT_W'(REC_FILT_CYCLES));
    endproperty
    a_chart_width: assert property (p_chart_width)
        else $error("chart recording filter width is not fixed");
    property p_div_width_cap;
        @(posedge core_clk_in) disable iff (reset_in)
        !is_chart |-> (tenths_lim <= FILT_TENTHS_MAX);
    endproperty
    a_div_width_cap: assert property (p_div_width_cap)
        else $error("division filter width above 10.0");
    property p_drop_gate;
        @(posedge core_clk_in) disable iff (reset_in)
        !cfg_in.drop_range_ok |-> !drop_evt;
    endproperty
    a_drop_gate: assert property (p_drop_gate)
        else $error("voltage drop fired on an unsupported range");
    property p_drop_level;
        @(posedge core_clk_in) disable iff (reset_in)
        drop_evt |-> (peak_q < {1'b0, cfg_in.drop_level});
    endproperty
    a_drop_level: assert property (p_drop_level)
        else $error("voltage drop fired with peak at or above level");
    property p_rms_value;
        @(posedge core_clk_in) disable iff (reset_in)
        ce_in ##1 $stable(cfg_in.drop_level) |->
            (drop_rms_out == rms_prod[Q15_SHIFT +: SMP_W]);
    endproperty
    a_rms_value: assert property (p_rms_value)
        else $error("rms value does not follow drop level");
    property p_period_restart;
        @(posedge core_clk_in) disable iff (reset_in)
        xing |=> (per_cnt_q == '0) && per_armed_q;
    endproperty
    a_period_restart: assert property (p_period_restart)
        else $error("period count did not restart at crossing");
    property p_early_pos;
        @(posedge core_clk_in) disable iff (reset_in)
        (per_early && per_mode && !cfg_in.link_and) |=>
            trig_out && (trig_pos_out == $past(idx_q));
    endproperty
    a_early_pos: assert property (p_early_pos)
        else $error("early crossing trigger position wrong");
    property p_late_once;
        @(posedge core_clk_in) disable iff (reset_in)
        per_late |=> per_exp_q;
    endproperty
    a_late_once: assert property (p_late_once)
        else $error("period expiry not latched after firing");
    property p_and_link;
        @(posedge core_clk_in) disable iff (reset_in)
        (ce_in && cfg_in.link_and && !other_met_in) |=> !trig_out;
    endproperty
    a_and_link: assert property (p_and_link)
        else $error("AND link fired with other source unmet");
endmodule
